// [shared/tpw_defs.vh]
// Register map, field positions and reset values of the PWM timer.
`ifndef TPW_DEFS_VH
`define TPW_DEFS_VH
`define TPW_ADDR_CTRL 8'h00
`define TPW_ADDR_OUT 8'h04
`define TPW_ADDR_IN 8'h08
`define TPW_ADDR_EDGE 8'h0c
`define TPW_ADDR_OPT 8'h10
`define TPW_ADDR_CNT 8'h14
`define TPW_ADDR_CMP0 8'h18
`define TPW_ADDR_CMP1 8'h1c
`define TPW_ADDR_CMP2 8'h20
`define TPW_ADDR_CMP3 8'h24
`define TPW_ADDR_STAT 8'h28
`define TPW_CTRL_RUN 7
`define TPW_CTRL_MODE_MSB 2
`define TPW_CTRL_MODE_LSB 0
`define TPW_MODE_PWM 3'h4
`define TPW_MODE_ONESHOT 3'h3
`define TPW_OUT_OE0 0
`define TPW_OUT_OL0 1
`define TPW_EDGE_EVT_MSB 3
`define TPW_EDGE_EVT_LSB 2
`define TPW_EDGE_TRG_MSB 1
`define TPW_EDGE_TRG_LSB 0
`define TPW_STAT_RUN 0
`define TPW_STAT_PEND 1
`define TPW_STAT_PWM_LSB 2
`define TPW_STAT_TOG 5
`define TPW_CTRL_RST 8'h00
`define TPW_OUT_RST 8'h00
`define TPW_IN_RST 8'h00
`define TPW_EDGE_RST 8'h00
`define TPW_OPT_RST 8'h00
`define TPW_CMP_RST 16'h0000
`define TPW_CNT_IDLE 16'hffff
`define TPW_CNT_ZERO 16'h0000
`define TPW_RD_ZERO 16'h0000
`endif

// [tb/testbench.sv]
// Self-checking bench for the PWM timer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic clr = 1'b1;
  logic [15:0] rv;
  wire [15:0] rd_data;
  wire [2:0] pwm_out_pin, pwm_out_oe, duty_match_irq;
  wire toggle_out_pin, period_match_irq;
  wire [8:0][7:0] tally;
  int err_total = 0;
  int comparisons = 0;
  tpw_top dut (.sys_clk(sys_clk), .srst(srst), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .pwm_out_pin(pwm_out_pin), .pwm_out_oe(pwm_out_oe),
    .toggle_out_pin(toggle_out_pin), .period_match_irq(period_match_irq),
    .duty_match_irq(duty_match_irq));
  tpw_load u_load (.sys_clk(sys_clk), .clr(clr), .pwm_out_pin(pwm_out_pin),
    .toggle_out_pin(toggle_out_pin), .period_match_irq(period_match_irq),
    .duty_match_irq(duty_match_irq), .tally(tally));
  initial forever #25 sys_clk = ~sys_clk;
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_cnt(input logic [8:0][7:0] e, input logic [8:0] m);
    for (int i = 0; i < 9; i++) begin
      if (m[i]) begin
        comparisons++;
        if (tally[i] !== e[i]) begin
          err_total++;
          $display("[FAIL] %0t tally %0d is %0d not %0d", $time, i,
            tally[i], e[i]);
        end
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 rv = rd_data;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk_reg(rv, e);
  endtask
  // Counts the n cycles that follow the cycle in progress.
  task automatic meas(input int n);
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (n) @(posedge sys_clk);
    clr <= 1'b1;
    #1;
  endtask
  task automatic t_reset;
    rdc(8'h14, 16'hffff);
    rdc(8'h00, 16'h0000);
    rdc(8'h1c, 16'h0000);
    rdc(8'h2c, 16'h0000);
  endtask
  task automatic t_regs;
    wr(8'h08, 16'h00ff);
    wr(8'h10, 16'h00ff);
    wr(8'h0c, 16'h000c);
    rdc(8'h0c, 16'h000c);
    wr(8'h14, 16'h1234);
    rdc(8'h14, 16'hffff);
  endtask
  // Period 4; duties 2, 0 and 4 give normal, 0% and 100% outputs.
  task automatic t_pwm;
    wr(8'h18, 16'h0003);
    wr(8'h20, 16'h0000);
    wr(8'h24, 16'h0004);
    wr(8'h1c, 16'h0002);
    wr(8'h04, 16'h0075);
    wr(8'h00, 16'h0084);
    meas(12);
    chk_cnt({8'h03, 8'h08, 8'h00, 8'h03, 8'h03, 8'h02, 8'h0c, 8'h0c,
      8'h06}, 9'h1ff);
    rd(8'h14);
    chk_reg(rv, 16'h0001);
  endtask
  task automatic t_reload;
    wr(8'h18, 16'h0005);
    wr(8'h20, 16'h0001);
    meas(12);
    chk_cnt({8'h03, 8'h00, 8'h00, 8'h03, 8'h00, 8'h03, 8'h00, 8'h00,
      8'h06}, 9'h129);
    wr(8'h1c, 16'h0002);
    #1;
    repeat (40) if (period_match_irq !== 1'b1) @(posedge sys_clk) #1;
    chk_reg({15'h0000, period_match_irq}, 16'h0001);
    meas(12);
    chk_cnt({8'h02, 8'h06, 8'h02, 8'h02, 8'h02, 8'h02, 8'h08, 8'h0a,
      8'h04}, 9'h1ff);
  endtask
  task automatic t_outs;
    wr(8'h04, 16'h000a);
    rdc(8'h28, 16'h0021);
    meas(8);
    chk_cnt({8'h00, 8'h08, 56'h0}, 9'h187);
    chk_reg({13'h0000, pwm_out_oe}, 16'h0000);
  endtask
  task automatic t_mode;
    wr(8'h04, 16'h0075);
    wr(8'h00, 16'h0083);
    rdc(8'h14, 16'hffff);
    meas(8);
    chk_cnt({56'h0, 8'h08, 8'h00}, 9'h1ff);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset;
    t_regs;
    t_pwm;
    t_reload;
    t_outs;
    t_mode;
    close_out;
  end
  initial begin
    #100000;
    err_total++;
    close_out;
  end
endmodule // testbench
`default_nettype wire

// [tb/tpw_load.sv]
// Load on the timer pins that tallies levels and events over a window.
`timescale 1ns/1ps
`default_nettype none
module tpw_load (
  input wire logic sys_clk,
  input wire logic clr,
  input wire logic [2:0] pwm_out_pin,
  input wire logic toggle_out_pin,
  input wire logic period_match_irq,
  input wire logic [2:0] duty_match_irq,
  output logic [8:0][7:0] tally
);
  logic tog_last_q;
  logic [8:0] seen;
  // Tallies use sampled levels so a window is an exact cycle count.
  assign seen = {toggle_out_pin != tog_last_q, toggle_out_pin,
    duty_match_irq, period_match_irq, pwm_out_pin};
  always_ff @(posedge sys_clk) begin
    tog_last_q <= toggle_out_pin;
    for (int i = 0; i < 9; i++) begin
      tally[i] <= clr ? 8'h00 : tally[i] + {7'h00, seen[i]};
    end
  end
endmodule // tpw_load
`default_nettype wire

// [tb/tpw_props.sv]
// Port-level assertions and covers for the PWM timer.
`timescale 1ns/1ps
`default_nettype none
module tpw_props (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rd_data,
  input wire logic [2:0] pwm_out_pin,
  input wire logic [2:0] pwm_out_oe,
  input wire logic toggle_out_pin,
  input wire logic period_match_irq,
  input wire logic [2:0] duty_match_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_rd_idle_zero:
    assert property (!$past(rd_stb) |-> rd_data == 16'h0000)
    else $error("read data outside its slot");
  a_period_pulse_one:
    assert property (period_match_irq |=> !period_match_irq)
    else $error("period pulse longer than one cycle");
  a_duty_pulse_one:
    assert property ($rose(duty_match_irq[0]) |=> $fell(duty_match_irq[0]))
    else $error("duty pulse longer than one cycle");
  a_pins_off_low:
    assert property ((pwm_out_pin & ~pwm_out_oe) == 3'h0)
    else $error("disabled pin not low");
  a_oe_follows_write:
    assert property (wr_stb && addr == 8'h04 |-> ##2 pwm_out_oe ==
      {$past(wr_data[6], 2), $past(wr_data[4], 2), $past(wr_data[2], 2)})
    else $error("pin enables do not follow write");
  a_pin_change_cause:
    assert property ($changed(pwm_out_pin[0]) |-> period_match_irq ||
      duty_match_irq[0] || $past(wr_stb) || $past(wr_stb, 2))
    else $error("pin 1 moved without clear or match");
  a_toggle_cause:
    assert property ($changed(toggle_out_pin) |-> period_match_irq ||
      $past(wr_stb) || $past(wr_stb, 2))
    else $error("toggle pin moved without clear");
  a_stop_quiet:
    assert property (wr_stb && addr == 8'h00 && (!wr_data[7] ||
      wr_data[2:0] != 3'h4) |-> ##2 !period_match_irq && !duty_match_irq)
    else $error("pulse after leaving PWM run");
  c_period: cover property (period_match_irq);
  c_duty: cover property (duty_match_irq[0]);
  c_stop: cover property (wr_stb && addr == 8'h00 && !wr_data[7]);
endmodule // tpw_props
bind tpw_top tpw_props u_props (.sys_clk(sys_clk), .srst(srst),
  .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rd_data(rd_data), .pwm_out_pin(pwm_out_pin), .pwm_out_oe(pwm_out_oe),
  .toggle_out_pin(toggle_out_pin), .period_match_irq(period_match_irq),
  .duty_match_irq(duty_match_irq));
`default_nettype wire

// [verilog/tpw_chan.v]
// One duty channel: compare shadow, PWM level and duty-match pulse.
`timescale 1ns/1ps
`default_nettype none
`include "tpw_defs.vh"
module tpw_chan (
  input wire sys_clk,
  input wire srst,
  input wire run,
  input wire clear,
  input wire load,
  input wire [15:0] duty_reg,
  input wire [15:0] cnt_next,
  input wire oe,
  input wire ol,
  output reg pin_q,
  output reg oe_q,
  output reg irq_q
);
  reg [15:0] sh_q;
  reg act_q;
  wire [15:0] sh_d;
  wire match;
  wire act_d;
  assign sh_d = load ? duty_reg : sh_q;
  // Judged on the next count so the pulse lands with the match.
  assign match = run & (cnt_next == sh_d);
  // A zero duty matches at the clear and wins; duty of period plus one
  // never matches, so the level stays active.
  assign act_d = !run ? 1'b0 : (match ? 1'b0 :
                 (clear ? 1'b1 : act_q));
  always @(posedge sys_clk) begin
    if (srst) begin
      sh_q <= `TPW_CMP_RST;
      act_q <= 1'b0;
      pin_q <= 1'b0;
      oe_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      act_q <= act_d;
      pin_q <= oe ? (act_d ^ ol) : 1'b0;
      oe_q <= oe;
      irq_q <= match;
    end
  end
endmodule // tpw_chan
`default_nettype wire

// [verilog/tpw_count.v]
// Period counter, period shadow, period-match pulse and toggle pin.
`timescale 1ns/1ps
`default_nettype none
`include "tpw_defs.vh"
module tpw_count (
  input wire sys_clk,
  input wire srst,
  input wire run,
  input wire load,
  input wire [15:0] period_reg,
  input wire oe0,
  input wire ol0,
  output wire [15:0] cnt_next,
  output wire clear,
  output wire wrap,
  output reg [15:0] cnt_q,
  output reg period_irq_q,
  output reg tog_pin_q
);
  reg running_q;
  reg [15:0] sh0_q;
  reg tog_q;
  wire tog_d;
  wire start;
  assign start = run & ~running_q;
  assign wrap = run & running_q & (cnt_q == sh0_q);
  assign clear = start | wrap;
  // Idle at all ones, step to zero on start, then count up.
  assign cnt_next = !run ? `TPW_CNT_IDLE :
                    clear ? `TPW_CNT_ZERO : cnt_q + 16'h0001;
  assign tog_d = !run ? ol0 : (clear ? ~tog_q : tog_q);
  always @(posedge sys_clk) begin
    if (srst) begin
      running_q <= 1'b0;
      cnt_q <= `TPW_CNT_IDLE;
      sh0_q <= `TPW_CMP_RST;
      tog_q <= 1'b0;
      period_irq_q <= 1'b0;
      tog_pin_q <= 1'b0;
    end else begin
      running_q <= run;
      cnt_q <= cnt_next;
      if (load) begin
        sh0_q <= period_reg;
      end
      tog_q <= tog_d;
      period_irq_q <= wrap;
      tog_pin_q <= oe0 ? tog_d : ol0;
    end
  end
endmodule // tpw_count
`default_nettype wire

// [verilog/tpw_top.v]
// PWM output mode of a four-channel 16-bit timer with its registers.
//
// How it works
// - Compare pulse of channels 1-3 comes in the match cycle, in PWM mode only.
// - Mode field value 100 selects PWM operation.
// - With run bit set in PWM mode, pins 1-3 carry PWM waveforms.
// - Pin 0 is a square wave, half period equal to PWM period.
// - Counter idles at FFFFH, steps to 0000H on start, then counts.
// - Active width equals the channel's compare value in count clocks.
// - Period is period value plus one; counter clears after matching it.
// - Compare writes during counting take effect only at counter clear.
// - Period-match pulse comes with the counter clearing to 0000H.
// - Duty-match pulse comes in the cycle counter equals the shadow.
// - Each of four pins has an enable bit: 0 off, 1 on.
// - Level bit of pins 1-3 picks polarity: 0 high, 1 low active.
// - Level bit of pin 0 picks its level while disabled.
// - Only event edge field matters; software keeps trigger bits zero. Here no edge bit, event or trigger, drives anything.
// - Counter readback returns the live counter value.
// - Input control and option registers have no effect here.
// - Only a channel-1 compare write arms the shadow transfer.
// - Zero duty gives steady inactive output; pulses still recur.
// - Duty of period plus one gives steady active output.
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tpw_defs.vh"
module tpw_top (
  input wire sys_clk,
  input wire srst,
  input wire [7:0] addr,
  input wire [15:0] wr_data,
  input wire wr_stb,
  input wire rd_stb,
  output reg [15:0] rd_data,
  output wire [2:0] pwm_out_pin,
  output wire [2:0] pwm_out_oe,
  output wire toggle_out_pin,
  output wire period_match_irq,
  output wire [2:0] duty_match_irq
);
  // Software-visible registers.
  reg [7:0] ctrl_q;
  reg [7:0] output_control_q;
  reg [7:0] input_control_q;
  reg [7:0] edge_select_control_q;
  reg [7:0] option_control_q;
  reg [15:0] period_compare_q;
  reg [15:0] duty_compare_one_q;
  reg [15:0] duty_compare_two_q;
  reg [15:0] duty_compare_three_q;

  // Transfer of compare registers into the shadows.
  reg pend_q;
  reg pend_d;

  // Read path.
  reg [15:0] rd_d;

  // Decoded bus strobes.
  wire wr_ctrl;
  wire wr_out;
  wire wr_in;
  wire wr_edge;
  wire wr_opt;
  wire wr_cmp0;
  wire wr_cmp1;
  wire wr_cmp2;
  wire wr_cmp3;

  // Mode and run control.
  wire [2:0] operating_mode_field;
  wire count_run_bit;
  wire pwm_mode;
  wire run;

  // Counter side.
  wire [15:0] cnt_next;
  wire [15:0] cnt_q;
  wire clear;
  wire wrap;
  wire load;

  // Channel controls gathered into vectors for the generate loop, and the status word.
  wire [2:0] ch_oe;
  wire [2:0] ch_ol;
  wire [47:0] duty_vec;
  wire [7:0] status;

  assign wr_ctrl = wr_stb & (addr == `TPW_ADDR_CTRL);
  assign wr_out = wr_stb & (addr == `TPW_ADDR_OUT);
  assign wr_in = wr_stb & (addr == `TPW_ADDR_IN);
  assign wr_edge = wr_stb & (addr == `TPW_ADDR_EDGE);
  assign wr_opt = wr_stb & (addr == `TPW_ADDR_OPT);
  assign wr_cmp0 = wr_stb & (addr == `TPW_ADDR_CMP0);
  assign wr_cmp1 = wr_stb & (addr == `TPW_ADDR_CMP1);
  assign wr_cmp2 = wr_stb & (addr == `TPW_ADDR_CMP2);
  assign wr_cmp3 = wr_stb & (addr == `TPW_ADDR_CMP3);

  assign operating_mode_field =
    ctrl_q[`TPW_CTRL_MODE_MSB:`TPW_CTRL_MODE_LSB];
  assign count_run_bit = ctrl_q[`TPW_CTRL_RUN];
  assign pwm_mode = (operating_mode_field == `TPW_MODE_PWM);
  // Any other mode leaves the counter idle and all pins quiet. The
  // one-shot mode is not built here, so selecting it parks the counter
  // at all ones rather than waiting for a trigger.
  assign run = count_run_bit & pwm_mode;

  // While stopped the shadows follow the registers, so the first period
  // after start already uses fresh values. While running, only the clear
  // after a channel-1 write moves them.
  assign load = ~run | (wrap & pend_q);

  // Pin k of 1..3 uses bits 2k (enable) and 2k+1 (level).
  assign ch_oe = {output_control_q[6], output_control_q[4],
                  output_control_q[2]};
  assign ch_ol = {output_control_q[7], output_control_q[5],
                  output_control_q[3]};
  assign duty_vec = {duty_compare_three_q, duty_compare_two_q,
                     duty_compare_one_q};

  // Status word for polling, since the block has no interrupt logic of
  // its own beyond the match pulses: bit 0 running, bit 1 transfer
  // pending, bits 4:2 the PWM pins and bit 5 the toggle pin. Software
  // should see the pending bit fall before it rewrites any compare.
  assign status = {2'h0, toggle_out_pin, pwm_out_pin, pend_q, run};

  // Register writes. Input control and option are kept for readback
  // only and steer nothing in this mode.
  always @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= `TPW_CTRL_RST;
      output_control_q <= `TPW_OUT_RST;
      input_control_q <= `TPW_IN_RST;
      edge_select_control_q <= `TPW_EDGE_RST;
      option_control_q <= `TPW_OPT_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wr_data[7:0];
      end
      if (wr_out) begin
        output_control_q <= wr_data[7:0];
      end
      if (wr_in) begin
        input_control_q <= wr_data[7:0];
      end
      // The trigger edge bits are stored but drive nothing; the event edge
      // field is stored as well and drives nothing either.
      if (wr_edge) begin
        edge_select_control_q <= wr_data[7:0];
      end
      if (wr_opt) begin
        option_control_q <= wr_data[7:0];
      end
    end
  end

  // Compare registers. Software is expected to write period and
  // channels 2 and 3 before channel 1, and not to write again until the
  // period match; a write that collides with a transfer leaves the
  // shadow with whatever value the register held that cycle.
  always @(posedge sys_clk) begin
    if (srst) begin
      period_compare_q <= `TPW_CMP_RST;
      duty_compare_one_q <= `TPW_CMP_RST;
      duty_compare_two_q <= `TPW_CMP_RST;
      duty_compare_three_q <= `TPW_CMP_RST;
    end else begin
      if (wr_cmp0) begin
        period_compare_q <= wr_data;
      end
      if (wr_cmp1) begin
        duty_compare_one_q <= wr_data;
      end
      if (wr_cmp2) begin
        duty_compare_two_q <= wr_data;
      end
      if (wr_cmp3) begin
        duty_compare_three_q <= wr_data;
      end
    end
  end

  // Transfer arming. A channel-1 write in the same cycle as the clear
  // keeps the request standing for the next clear.
  always @* begin
    pend_d = pend_q;
    if (!run) begin
      pend_d = 1'b0;
    end else if (wr_cmp1) begin
      pend_d = 1'b1;
    end else if (wrap) begin
      pend_d = 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // Read mux; unmapped addresses and the unused upper bits read zero.
  // The counter is read live, not latched, so the whole 16-bit word
  // comes in one access and no half-word pairing is needed.
  always @* begin
    rd_d = `TPW_RD_ZERO;
    case (addr)
      `TPW_ADDR_CTRL: begin
        rd_d = {8'h00, ctrl_q};
      end
      `TPW_ADDR_OUT: begin
        rd_d = {8'h00, output_control_q};
      end
      `TPW_ADDR_IN: begin
        rd_d = {8'h00, input_control_q};
      end
      `TPW_ADDR_EDGE: begin
        rd_d = {8'h00, edge_select_control_q};
      end
      `TPW_ADDR_OPT: begin
        rd_d = {8'h00, option_control_q};
      end
      `TPW_ADDR_CNT: begin
        rd_d = cnt_q;
      end
      `TPW_ADDR_CMP0: begin
        rd_d = period_compare_q;
      end
      `TPW_ADDR_CMP1: begin
        rd_d = duty_compare_one_q;
      end
      `TPW_ADDR_CMP2: begin
        rd_d = duty_compare_two_q;
      end
      `TPW_ADDR_CMP3: begin
        rd_d = duty_compare_three_q;
      end
      `TPW_ADDR_STAT: begin
        rd_d = {8'h00, status};
      end
      default: begin
        rd_d = `TPW_RD_ZERO;
      end
    endcase
  end

  // Read data stand for the single cycle after the strobe.
  always @(posedge sys_clk) begin
    if (srst) begin
      rd_data <= `TPW_RD_ZERO;
    end else if (rd_stb) begin
      rd_data <= rd_d;
    end else begin
      rd_data <= `TPW_RD_ZERO;
    end
  end

  // Pin 0 has its own enable and level bits but no duty channel; the
  // counter block owns it because it only changes at a clear.
  tpw_count u_count (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(run),
    .load(load),
    .period_reg(period_compare_q),
    .oe0(output_control_q[`TPW_OUT_OE0]),
    .ol0(output_control_q[`TPW_OUT_OL0]),
    .cnt_next(cnt_next),
    .clear(clear),
    .wrap(wrap),
    .cnt_q(cnt_q),
    .period_irq_q(period_match_irq),
    .tog_pin_q(toggle_out_pin)
  );

  // Channels share the counter's next value so that each duty match
  // lands in the same cycle in which the counter shows it.
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_chan
      tpw_chan u_chan (
        .sys_clk(sys_clk),
        .srst(srst),
        .run(run),
        .clear(clear),
        .load(load),
        .duty_reg(duty_vec[16*k+15:16*k]),
        .cnt_next(cnt_next),
        .oe(ch_oe[k]),
        .ol(ch_ol[k]),
        .pin_q(pwm_out_pin[k]),
        .oe_q(pwm_out_oe[k]),
        .irq_q(duty_match_irq[k])
      );
    end
  endgenerate
endmodule // tpw_top
`default_nettype wire
